// *** logic/rtcpm_cfg.svh ***
// constants for the rtc output pin routing block
`ifndef RTCPM_CFG_SVH
`define RTCPM_CFG_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define RTCPM_OFS_ROUTE       8'h11
`define RTCPM_OFS_SQW         8'h13

// ----------------------------------------------------------------------
// output_routing_control fields
// ----------------------------------------------------------------------
`define RTCPM_PRI_SRC_LSB     0
`define RTCPM_PRI_SRC_W       2
`define RTCPM_SEC_SRC_LSB     2
`define RTCPM_SEC_SRC_W       3
`define RTCPM_LEVEL_B_BIT     5
`define RTCPM_LEVEL_A_BIT     7
`define RTCPM_ROUTE_RST       8'ha0

// ----------------------------------------------------------------------
// square_wave_config fields
// ----------------------------------------------------------------------
`define RTCPM_SQUARE_WAVE_ENABLE_BIT        7
`define RTCPM_SQW_RST         8'h00

// ----------------------------------------------------------------------
// source select encodings
// ----------------------------------------------------------------------
`define RTCPM_PRI_LEVEL       2'h0
`define RTCPM_PRI_IRQ_N       2'h1
`define RTCPM_PRI_SQW         2'h2
`define RTCPM_PRI_ALARM_N     2'h3
`define RTCPM_SEC_LEVEL       3'h0
`define RTCPM_SEC_SQW         3'h1
`define RTCPM_SEC_IRQ_N       3'h2
`define RTCPM_SEC_ALARM_N     3'h3
`define RTCPM_SEC_TIMER       3'h4
`define RTCPM_SEC_TIMER_N     3'h5

// ----------------------------------------------------------------------
// synchroniser depth
// ----------------------------------------------------------------------
`define RTCPM_SYNC_STAGES     2

`endif

// *** logic/rtcpm_pkg.sv ***
// types shared by the rtc output pin routing block
package rtcpm_pkg;
    typedef logic [7:0] rtcpm_byte_t;
    // primary pin is held low until the serial side reports ready
    typedef enum logic {RTCPM_HOLD, RTCPM_LIVE} rtcpm_pin_state_e;
endpackage

// *** logic/rtcpm_ext_in.sv ***
// pin synchroniser with level, polarity event and any-edge outputs
`timescale 1ns/1ps
`include "rtcpm_cfg.svh"
module rtcpm_ext_in
    import rtcpm_pkg::*;
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic nrst,
    // pin and control
    input  wire logic pin,
    input  wire logic enable,
    input  wire logic polarity,
    // results
    output logic      level,
    output logic      event_pulse,
    output logic      any_edge
);
    logic       meta_ff;
    logic       sync_ff;
    logic       last_ff;
    logic       ev_ff;
    logic       edge_ff;
    logic       hit;

    // -------------------------------------------------------------------
    // two flops before anything looks at the pin
    // -------------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end else begin
            meta_ff <= pin;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    // polarity high selects the rising edge, low the falling edge
    assign hit = polarity ? (sync_ff & ~last_ff) : (~sync_ff & last_ff);

    // registered event and edge pulses
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ev_ff   <= 1'b0;
            edge_ff <= 1'b0;
        end else begin
            ev_ff   <= enable & hit;
            edge_ff <= sync_ff ^ last_ff;
        end
    end

    assign level       = sync_ff;
    assign event_pulse = ev_ff;
    assign any_edge    = edge_ff;
endmodule // rtcpm_ext_in

// *** logic/rtcpm_src_sel.sv ***
// source selectors for the primary and secondary interrupt pins
`timescale 1ns/1ps
`include "rtcpm_cfg.svh"
module rtcpm_src_sel
    import rtcpm_pkg::*;
#(
    parameter logic [1:0] PRI_LEVEL   = `RTCPM_PRI_LEVEL,
    parameter logic [1:0] PRI_IRQ_N   = `RTCPM_PRI_IRQ_N,
    parameter logic [1:0] PRI_SQW     = `RTCPM_PRI_SQW,
    parameter logic [1:0] PRI_ALARM_N = `RTCPM_PRI_ALARM_N,
    parameter logic [2:0] SEC_LEVEL   = `RTCPM_SEC_LEVEL,
    parameter logic [2:0] SEC_SQW     = `RTCPM_SEC_SQW,
    parameter logic [2:0] SEC_IRQ_N   = `RTCPM_SEC_IRQ_N,
    parameter logic [2:0] SEC_ALARM_N = `RTCPM_SEC_ALARM_N,
    parameter logic [2:0] SEC_TIMER   = `RTCPM_SEC_TIMER,
    parameter logic [2:0] SEC_TIMER_N = `RTCPM_SEC_TIMER_N
)(
    // selects
    input  wire logic [1:0] pri_sel,
    input  wire logic [2:0] sec_sel,
    // sources
    input  wire logic       level_a,
    input  wire logic       level_b,
    input  wire logic       sqw_gated_a,
    input  wire logic       sqw_gated_b,
    input  wire logic       irq_comb,
    input  wire logic       alarm_interrupt,
    input  wire logic       timer_event,
    // selected levels
    output logic            pri_level,
    output logic            sec_level
);
    // each code names one source; unlisted secondary codes fall to level
    always_comb begin
        unique case (pri_sel)
            PRI_IRQ_N:   pri_level = ~irq_comb;
            PRI_SQW:     pri_level = sqw_gated_a;
            PRI_ALARM_N: pri_level = ~alarm_interrupt;
            default:     pri_level = level_a;
        endcase
    end

    // secondary select; codes above the timer pair are not defined
    always_comb begin
        case (sec_sel)
            SEC_SQW:     sec_level = sqw_gated_b;
            SEC_IRQ_N:   sec_level = ~irq_comb;
            SEC_ALARM_N: sec_level = ~alarm_interrupt;
            SEC_TIMER:   sec_level = timer_event;
            SEC_TIMER_N: sec_level = ~timer_event;
            default:     sec_level = level_b;
        endcase
    end
endmodule // rtcpm_src_sel

// *** logic/rtcpm_pin_route.sv ***
// rtc interrupt and clock output pin routing, top level
`timescale 1ns/1ps
`include "rtcpm_cfg.svh"
module rtcpm_pin_route
    import rtcpm_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // register port from the serial engine
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire rtcpm_byte_t reg_wdata,
    input  wire logic        reg_rd,
    output rtcpm_byte_t      reg_rdata,
    output logic             reg_rvalid,
    input  wire logic        iface_ready,
    // host-driven pins
    input  wire logic        chip_select_n,
    input  wire logic        external_event_in,
    input  wire logic        watchdog_kick_in,
    // external input control
    input  wire logic        ext_one_enable,
    input  wire logic        ext_one_polarity,
    input  wire logic        ext_two_enable,
    input  wire logic        ext_two_polarity,
    // external input results
    output logic             external_pin_level,
    output logic             watchdog_pin_level,
    output logic             ext_one_event,
    output logic             ext_two_event,
    output logic             watchdog_restart,
    output logic             chip_selected,
    // internal sources
    input  wire logic        irq_comb,
    input  wire logic        alarm_interrupt,
    input  wire logic        timer_event,
    input  wire logic        square_wave,
    // output pins
    output logic             primary_irq_pin,
    output logic             secondary_irq_pin_o,
    output logic             secondary_irq_pin_oe,
    output logic             timer_event_pin_n_o,
    output logic             timer_event_pin_n_oe,
    output logic             clock_output_pin
);
    // -------------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------------
    rtcpm_byte_t      route_ff;
    rtcpm_byte_t      sqw_cfg_ff;
    rtcpm_byte_t      rdata_ff;
    rtcpm_byte_t      nxt_rdata;
    logic             rvalid_ff;
    rtcpm_pin_state_e state_ff;
    rtcpm_pin_state_e nxt_state;
    logic             cs_meta_ff;
    logic             cs_sync_ff;
    logic             pri_pin_ff;
    logic             sec_drive_ff;
    logic             tmr_drive_ff;
    logic             clk_pin_ff;
    logic [1:0]       pin_in;
    logic [1:0]       pin_en;
    logic [1:0]       pin_pol;
    logic [1:0]       pin_lvl;
    logic [1:0]       pin_evt;
    logic [1:0]       pin_edge;
    logic             wr_ok;
    logic             wr_route;
    logic             wr_sqw;
    logic             level_a;
    logic             level_b;
    logic             square_wave_enable;
    logic             sqw_a;
    logic             sqw_b;
    logic             pri_level;
    logic             sec_level;
    logic [1:0]       pri_sel;
    logic [2:0]       sec_sel;

    // address match used for both write and read decode
    function automatic logic hit_addr(input logic [7:0] a,
                                      input logic [7:0] ofs);
        hit_addr = (a == ofs);
    endfunction

    // -------------------------------------------------------------------
    // chip select synchroniser
    // -------------------------------------------------------------------
    // the pin comes from the host, so two flops before use
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cs_meta_ff <= 1'b0;
            cs_sync_ff <= 1'b0;
        end else begin
            cs_meta_ff <= ~chip_select_n;
            cs_sync_ff <= cs_meta_ff;
        end
    end

    assign chip_selected = cs_sync_ff;

    // -------------------------------------------------------------------
    // external inputs
    // -------------------------------------------------------------------
    // index 0 is the external event pin, index 1 the watchdog pin
    assign pin_in  = {watchdog_kick_in, external_event_in};
    assign pin_en  = {ext_two_enable, ext_one_enable};
    assign pin_pol = {ext_two_polarity, ext_one_polarity};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ext
            rtcpm_ext_in u_ext (
                .mclk        (mclk),
                .nrst        (nrst),
                .pin         (pin_in[gi]),
                .enable      (pin_en[gi]),
                .polarity    (pin_pol[gi]),
                .level       (pin_lvl[gi]),
                .event_pulse (pin_evt[gi]),
                .any_edge    (pin_edge[gi])
            );
        end
    endgenerate

    // levels and events out to status and interrupt logic
    assign external_pin_level = pin_lvl[0];
    assign watchdog_pin_level = pin_lvl[1];
    assign ext_one_event      = pin_evt[0];
    assign ext_two_event      = pin_evt[1];
    // either edge restarts the watchdog, whatever the interrupt setup
    assign watchdog_restart   = pin_edge[1];

    // -------------------------------------------------------------------
    // register writes
    // -------------------------------------------------------------------
    // writes only land while the host holds the device selected, which
    // keeps a floating select during power moves from corrupting routing
    assign wr_ok    = reg_wr & cs_sync_ff;
    assign wr_route = wr_ok & hit_addr(reg_addr, `RTCPM_OFS_ROUTE);
    assign wr_sqw   = wr_ok & hit_addr(reg_addr, `RTCPM_OFS_SQW);

    // routing register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            route_ff <= `RTCPM_ROUTE_RST;
        end else if (wr_route) begin
            route_ff <= reg_wdata;
        end
    end

    // square wave configuration register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sqw_cfg_ff <= `RTCPM_SQW_RST;
        end else if (wr_sqw) begin
            sqw_cfg_ff <= reg_wdata;
        end
    end

    // -------------------------------------------------------------------
    // register reads
    // -------------------------------------------------------------------
    // unmapped offsets read as zero
    assign nxt_rdata =
        hit_addr(reg_addr, `RTCPM_OFS_ROUTE) ? route_ff   :
        hit_addr(reg_addr, `RTCPM_OFS_SQW)   ? sqw_cfg_ff :
        8'h00;

    // read data is held until the next read
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdata_ff  <= 8'h00;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= reg_rd;
            if (reg_rd) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    assign reg_rdata  = rdata_ff;
    assign reg_rvalid = rvalid_ff;

    // -------------------------------------------------------------------
    // field extraction
    // -------------------------------------------------------------------
    assign pri_sel = route_ff[`RTCPM_PRI_SRC_LSB +: `RTCPM_PRI_SRC_W];
    assign sec_sel = route_ff[`RTCPM_SEC_SRC_LSB +: `RTCPM_SEC_SRC_W];
    assign level_a = route_ff[`RTCPM_LEVEL_A_BIT];
    assign level_b = route_ff[`RTCPM_LEVEL_B_BIT];
    assign square_wave_enable    = sqw_cfg_ff[`RTCPM_SQUARE_WAVE_ENABLE_BIT];

    // a disabled square wave falls back to the pin's static level bit
    assign sqw_a = square_wave_enable ? square_wave : level_a;
    assign sqw_b = square_wave_enable ? square_wave : level_b;

    // -------------------------------------------------------------------
    // source selection
    // -------------------------------------------------------------------
    rtcpm_src_sel u_sel (
        .pri_sel         (pri_sel),
        .sec_sel         (sec_sel),
        .level_a         (level_a),
        .level_b         (level_b),
        .sqw_gated_a     (sqw_a),
        .sqw_gated_b     (sqw_b),
        .irq_comb        (irq_comb),
        .alarm_interrupt (alarm_interrupt),
        .timer_event     (timer_event),
        .pri_level       (pri_level),
        .sec_level       (sec_level)
    );

    // -------------------------------------------------------------------
    // primary pin release state
    // -------------------------------------------------------------------
    // once the serial side is up the pin stays live until reset
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            RTCPM_HOLD: if (iface_ready) nxt_state = RTCPM_LIVE;
            RTCPM_LIVE: nxt_state = RTCPM_LIVE;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= RTCPM_HOLD;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // -------------------------------------------------------------------
    // output pin registers
    // -------------------------------------------------------------------
    // registered so a select change cannot glitch a pin mid-decode
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pri_pin_ff   <= 1'b0;
            sec_drive_ff <= 1'b0;
            tmr_drive_ff <= 1'b0;
            clk_pin_ff   <= 1'b0;
        end else begin
            pri_pin_ff   <= (state_ff == RTCPM_LIVE) & pri_level;
            sec_drive_ff <= ~sec_level;
            tmr_drive_ff <= timer_event;
            clk_pin_ff   <= sqw_a;
        end
    end

    // open drain pins only ever pull low
    assign primary_irq_pin      = pri_pin_ff;
    assign secondary_irq_pin_o  = 1'b0;
    assign secondary_irq_pin_oe = sec_drive_ff;
    assign timer_event_pin_n_o  = 1'b0;
    assign timer_event_pin_n_oe = tmr_drive_ff;
    assign clock_output_pin     = clk_pin_ff;
endmodule // rtcpm_pin_route

// *** testbench/rtcpm_pin_route_props.sv ***
// port-level checks for the rtc pin routing block
`timescale 1ns/1ps
module rtcpm_pin_route_props (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // inputs
    input wire logic iface_ready,
    input wire logic chip_select_n,
    input wire logic external_event_in,
    input wire logic watchdog_kick_in,
    input wire logic ext_one_enable,
    input wire logic ext_one_polarity,
    input wire logic ext_two_polarity,
    input wire logic timer_event,
    // outputs
    input wire logic external_pin_level,
    input wire logic watchdog_pin_level,
    input wire logic ext_one_event,
    input wire logic ext_two_event,
    input wire logic watchdog_restart,
    input wire logic chip_selected,
    input wire logic primary_irq_pin,
    input wire logic secondary_irq_pin_o,
    input wire logic timer_event_pin_n_o,
    input wire logic timer_event_pin_n_oe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    // remembers whether the serial side was ever ready since reset
    logic rdy_seen_ff;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) rdy_seen_ff <= 1'b0;
        else if (iface_ready) rdy_seen_ff <= 1'b1;
    end

    AST_PRI_HOLD: assert property (!rdy_seen_ff |-> !primary_irq_pin)
        else $error("primary pin high before ready");
    AST_TMR_ON: assert property (timer_event |=> timer_event_pin_n_oe)
        else $error("timer pin not pulled low");
    AST_TMR_OFF: assert property (!timer_event |=> !timer_event_pin_n_oe)
        else $error("timer pin pulled while idle");
    AST_TMR_DRAIN: assert property (!timer_event_pin_n_o)
        else $error("timer pin data not low");
    AST_SEC_DRAIN: assert property (!secondary_irq_pin_o)
        else $error("secondary pin data not low");
    AST_EXT1_GATE: assert property (!ext_one_enable [*4] |=> !ext_one_event)
        else $error("first event while disabled");
    AST_EXT1_POL: assert property (ext_one_event |->
        external_pin_level == ext_one_polarity)
        else $error("first event on wrong edge");
    AST_EXT2_POL: assert property (ext_two_event |->
        watchdog_pin_level == ext_two_polarity)
        else $error("second event on wrong edge");
    AST_EXT_LVL: assert property ($rose(external_event_in) |->
        ##[1:3] external_pin_level)
        else $error("external level not following pin");
    AST_WDI_LVL: assert property ($fell(watchdog_kick_in) |->
        ##[1:3] !watchdog_pin_level)
        else $error("watchdog level not following pin");
    AST_WDI_KICK: assert property ($changed(watchdog_pin_level) |->
        ##[0:2] watchdog_restart)
        else $error("watchdog restart missing");
    AST_CS_SYNC: assert property ($fell(chip_select_n) |->
        ##[1:3] chip_selected)
        else $error("chip select not seen");
endmodule // rtcpm_pin_route_props

bind rtcpm_pin_route rtcpm_pin_route_props u_props (
    .mclk(mclk), .nrst(nrst), .iface_ready(iface_ready),
    .chip_select_n(chip_select_n), .external_event_in(external_event_in),
    .watchdog_kick_in(watchdog_kick_in), .ext_one_enable(ext_one_enable),
    .ext_one_polarity(ext_one_polarity),
    .ext_two_polarity(ext_two_polarity), .timer_event(timer_event),
    .external_pin_level(external_pin_level),
    .watchdog_pin_level(watchdog_pin_level),
    .ext_one_event(ext_one_event), .ext_two_event(ext_two_event),
    .watchdog_restart(watchdog_restart), .chip_selected(chip_selected),
    .primary_irq_pin(primary_irq_pin),
    .secondary_irq_pin_o(secondary_irq_pin_o),
    .timer_event_pin_n_o(timer_event_pin_n_o),
    .timer_event_pin_n_oe(timer_event_pin_n_oe));

// *** testbench/rtcpm_host_model.sv ***
// host side: select line, interrupt input pins, pulled-up drains
`timescale 1ns/1ps
module rtcpm_host_model (
    // clock; the host model times its pin moves from the device clock
    input  wire logic mclk,
    // drain enables from the device
    input  wire logic sec_oe,
    input  wire logic tmr_oe,
    // host-driven pins
    output logic      chip_select_n,
    output logic      external_event_in,
    output logic      watchdog_kick_in,
    // resolved drain wires
    output logic      sec_wire,
    output logic      tmr_wire
);
    // pull-ups win whenever the device lets go of a drain
    assign sec_wire = sec_oe ? 1'b0 : 1'b1;
    assign tmr_wire = tmr_oe ? 1'b0 : 1'b1;

    // select idles high like its pull-up; inputs never float
    initial begin
        chip_select_n     = 1'b1;
        external_event_in = 1'b0;
        watchdog_kick_in  = 1'b0;
    end

    // select or release the device just after a rising edge
    task automatic select(input logic on);
        @(posedge mclk) #1;
        chip_select_n = ~on;
    endtask

    // move both interrupt pins together
    task automatic pins(input logic v);
        @(posedge mclk) #1;
        external_event_in = v;
        watchdog_kick_in  = v;
    endtask
endmodule // rtcpm_host_model

// *** testbench/rtcpm_pin_route_tb.sv ***
// self-checking bench for the rtc pin routing block
`timescale 1ns/1ps
`include "rtcpm_cfg.svh"
module rtcpm_pin_route_tb import rtcpm_pkg::*;;
    logic        mclk, nrst, reg_wr, reg_rd, reg_rvalid, iface_ready;
    logic [7:0]  reg_addr;
    rtcpm_byte_t reg_wdata, reg_rdata;
    logic chip_select_n, external_event_in, watchdog_kick_in;
    logic ext_one_enable, ext_one_polarity, ext_two_enable;
    logic ext_two_polarity, external_pin_level, watchdog_pin_level;
    logic ext_one_event, ext_two_event, watchdog_restart, chip_selected;
    logic irq_comb, alarm_interrupt, timer_event, square_wave;
    logic primary_irq_pin, secondary_irq_pin_o, secondary_irq_pin_oe;
    logic timer_event_pin_n_o, timer_event_pin_n_oe, clock_output_pin;
    logic sec_wire, tmr_wire;
    int   num_errors = 0, n_tests = 0, c1, c2, cw;

    rtcpm_pin_route DUT (.mclk, .nrst, .reg_addr, .reg_wr, .reg_wdata,
        .reg_rd, .reg_rdata, .reg_rvalid, .iface_ready, .chip_select_n,
        .external_event_in, .watchdog_kick_in, .ext_one_enable,
        .ext_one_polarity, .ext_two_enable, .ext_two_polarity,
        .external_pin_level, .watchdog_pin_level, .ext_one_event,
        .ext_two_event, .watchdog_restart, .chip_selected, .irq_comb,
        .alarm_interrupt, .timer_event, .square_wave, .primary_irq_pin,
        .secondary_irq_pin_o, .secondary_irq_pin_oe, .timer_event_pin_n_o,
        .timer_event_pin_n_oe, .clock_output_pin);

    rtcpm_host_model h (.mclk, .sec_oe(secondary_irq_pin_oe),
        .tmr_oe(timer_event_pin_n_oe), .chip_select_n, .external_event_in,
        .watchdog_kick_in, .sec_wire, .tmr_wire);

    // ------------------------------------------------------------------
    // clock, event counters, shared tasks
    // ------------------------------------------------------------------
    always #2 mclk = ~mclk;

    // pulses are one cycle wide, so count them on every edge
    always @(posedge mclk) begin
        if (ext_one_event === 1'b1) c1++;
        if (ext_two_event === 1'b1) c2++;
        if (watchdog_restart === 1'b1) cw++;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
            num_errors++;
        end
    endtask

    // one-cycle write strobe, taken at the next edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge mclk) #1;
        reg_wr = 1'b0;
    endtask

    // data and valid stand for the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk) #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge mclk) #1;
        reg_rd = 1'b0;
        chk({7'h00, reg_rvalid}, 8'h01);
        chk(reg_rdata, exp);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        rd(`RTCPM_OFS_ROUTE, `RTCPM_ROUTE_RST);
        rd(`RTCPM_OFS_SQW, `RTCPM_SQW_RST);
        chk(primary_irq_pin, 8'h00);
        iface_ready = 1'b1;
        tick(3);
        chk(primary_irq_pin, 8'h01);
        wr(`RTCPM_OFS_ROUTE, 8'h5a);
        rd(`RTCPM_OFS_ROUTE, `RTCPM_ROUTE_RST);
        h.select(1'b1);
        tick(3);
        wr(`RTCPM_OFS_ROUTE, 8'h5a);
        wr(`RTCPM_OFS_SQW, 8'hff);
        wr(8'h20, 8'h77);
        rd(`RTCPM_OFS_ROUTE, 8'h5a);
        rd(`RTCPM_OFS_SQW, 8'hff);
        rd(8'h20, 8'h00);
        $display("test regs done");
    endtask

    // every select code against independent source patterns
    task automatic t_route();
        logic ep, es, ec, et;
        for (int e = 0; e < 2; e++) begin
            for (int c = 0; c < 8; c++) begin
                for (int v = 0; v < 8; v++) begin
                    @(posedge mclk) #1;
                    irq_comb = v[2];
                    alarm_interrupt = v[0] ^ v[1];
                    square_wave = v[1] ^ v[2];
                    timer_event = v[0] ^ v[2];
                    wr(`RTCPM_OFS_ROUTE, {v[0], 1'b0, v[1], c[2:0], c[1:0]});
                    wr(`RTCPM_OFS_SQW, {e[0], 7'h00});
                    tick(3);
                    case (c[1:0])
                        `RTCPM_PRI_LEVEL: ep = v[0];
                        `RTCPM_PRI_IRQ_N: ep = ~irq_comb;
                        `RTCPM_PRI_SQW:   ep = e[0] ? square_wave : v[0];
                        default:          ep = ~alarm_interrupt;
                    endcase
                    case (c[2:0])
                        `RTCPM_SEC_SQW:     es = e[0] ? square_wave : v[1];
                        `RTCPM_SEC_IRQ_N:   es = ~irq_comb;
                        `RTCPM_SEC_ALARM_N: es = ~alarm_interrupt;
                        `RTCPM_SEC_TIMER:   es = timer_event;
                        `RTCPM_SEC_TIMER_N: es = ~timer_event;
                        default:            es = v[1];
                    endcase
                    ec = e[0] ? square_wave : v[0];
                    et = ~timer_event;
                    chk(primary_irq_pin, ep);
                    chk(sec_wire, es);
                    chk(clock_output_pin, ec);
                    chk(tmr_wire, et);
                end
            end
        end
        $display("test route done");
    endtask

    // both pins rise and fall once per round; one edge matches the polarity
    task automatic t_ext();
        for (int k = 0; k < 4; k++) begin
            @(posedge mclk) #1;
            ext_one_enable = k[0];
            ext_two_enable = k[0];
            ext_one_polarity = k[1];
            ext_two_polarity = k[1];
            c1 = 0;
            c2 = 0;
            cw = 0;
            h.pins(1'b1);
            tick(6);
            chk(external_pin_level, 8'h01);
            chk(watchdog_pin_level, 8'h01);
            h.pins(1'b0);
            tick(6);
            chk(external_pin_level, 8'h00);
            chk(watchdog_pin_level, 8'h00);
            chk(c1, k[0]);
            chk(c2, k[0]);
            chk(cw, 2);
        end
        $display("test ext done");
    endtask

    // ------------------------------------------------------------------
    // run control
    // ------------------------------------------------------------------
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // tests need about 1100 cycles; allow many times that
    initial begin
        #80000;
        num_errors++;
        complete_run();
    end

    initial begin
        mclk = 1'b0;
        nrst = 1'b0;
        {reg_wr, reg_rd, iface_ready} = 3'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        {ext_one_enable, ext_one_polarity} = 2'h0;
        {ext_two_enable, ext_two_polarity} = 2'h0;
        {irq_comb, alarm_interrupt, timer_event, square_wave} = 4'h0;
        repeat (12) @(posedge mclk);
        #1 nrst = 1'b1;
        t_regs();
        t_route();
        t_ext();
        complete_run();
    end
endmodule // rtcpm_pin_route_tb
